// ===== rtl/tc_pkg.sv
package tc_pkg;

    // ------------------------------------------------------------
    // Command codes on the command register
    // ------------------------------------------------------------
    localparam logic [7:0] START_CONVERT_CMD = 8'h51;
    localparam logic [7:0] READ_TEMP_CMD = 8'haa;
    localparam logic [7:0] CONFIG_ACCESS_CMD = 8'hac;
    localparam logic [7:0] HIGH_SETPOINT_ACCESS_CMD = 8'ha1;
    localparam logic [7:0] LOW_SETPOINT_ACCESS_CMD = 8'ha2;

    // ------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_RW_BIT = 11;
    localparam int CFG_ONESHOT_BIT = 0;
    localparam int CFG_POL_BIT = 1;
    localparam int CFG_RES_LO_BIT = 2;
    localparam int CFG_RES_HI_BIT = 3;
    localparam int CFG_HIFLAG_BIT = 6;
    localparam int CFG_LOFLAG_BIT = 5;
    localparam int CFG_DONE_BIT = 7;
    localparam int ST_ACK_BIT = 0;
    localparam int ST_NACK_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_PINS_LSB = 3;

    // ------------------------------------------------------------
    // Resolution, reset values and timing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RES_9, RES_10, RES_11, RES_12} res_t;

    localparam logic [15:0] HIGH_RST = 16'h5000;
    localparam logic [15:0] LOW_RST = 16'h4b00;
    localparam logic POL_RST = 1'b1;
    localparam logic ONESHOT_RST = 1'b0;
    localparam res_t RES_RST = RES_12;
    localparam logic [15:0] RESULT_MASK_12 = 16'hfff0;
    localparam real CONV9_MAX_MS = 93.75;
    localparam real CLK_MHZ = 40.0;
    localparam int CONV9_MAX_CYC = $rtoi(CONV9_MAX_MS * 1000.0 * CLK_MHZ);

    function automatic logic [15:0] res_mask(input res_t r);
        return RESULT_MASK_12 << (RES_12 - r);
    endfunction

endpackage

// ===== rtl/conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
    import tc_pkg::*;
    logic en;
    logic start;
    res_t res;
    logic busy;
    logic done;
    logic update;
    logic signed [15:0] result;
    logic signed [15:0] high_sp;
    logic signed [15:0] low_sp;
    logic active;
    logic hi_hit;
    logic lo_hit;
    modport ctl(output en, start, res, update, result, high_sp, low_sp,
                input busy, done, active, hi_hit, lo_hit);
    modport timer(input en, start, res, output busy, done);
    modport thermo(input en, update, result, high_sp, low_sp, output active, hi_hit, lo_hit);
endinterface
`default_nettype wire

// ===== rtl/conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
module conv_timer #(
    parameter int unsigned CONV9_CYCLES = tc_pkg::CONV9_MAX_CYC
) (
    input wire logic ref_clk, // Core clock
    input wire logic reset,   // Synchronous reset
    conv_if.timer cif         // Start and completion
);
    import tc_pkg::*;

    typedef struct packed {
        logic busy;
        logic [31:0] left;
    } tmr_t;

    tmr_t tmr_r;
    tmr_t tmr_nxt;

    assign cif.busy = tmr_r.busy;
    assign cif.done = tmr_r.busy && (tmr_r.left == 32'h1);

    always_comb begin
        tmr_nxt = tmr_r;
        if (cif.start && !tmr_r.busy) begin
            tmr_nxt.busy = 1'b1;
            tmr_nxt.left = 32'(CONV9_CYCLES) << cif.res;
        end else if (tmr_r.busy) begin
            tmr_nxt.left = tmr_r.left - 32'h1;
            tmr_nxt.busy = (tmr_r.left != 32'h1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tmr_r <= '0;
        end else if (cif.en) begin
            tmr_r <= tmr_nxt;
        end
    end

    // Elapsed busy cycles, seen only by the check below
    logic [31:0] elapsed_h;
    logic [31:0] expect_h;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            elapsed_h <= '0;
            expect_h <= '0;
        end else if (cif.en) begin
            if (cif.start && !tmr_r.busy) begin
                elapsed_h <= '0;
                expect_h <= 32'(CONV9_CYCLES) << cif.res;
            end else if (tmr_r.busy) begin
                elapsed_h <= elapsed_h + 32'h1;
            end
        end
    end

    property p_conv_length;
        @(posedge ref_clk) disable iff (reset)
        cif.done |-> (elapsed_h + 32'h1 == expect_h);
    endproperty
    a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

endmodule
`default_nettype wire

// ===== rtl/thermostat.sv
`timescale 1ns/1ps
`default_nettype none
module thermostat (
    input wire logic ref_clk, // Core clock
    input wire logic reset,   // Synchronous reset
    conv_if.thermo cif        // Result and setpoints
);
    import tc_pkg::*;

    typedef struct packed {
        logic active;
        logic hi_hit;
        logic lo_hit;
    } thr_t;

    thr_t thr_r;
    thr_t thr_nxt;
    logic ge_high;
    logic le_low;

    assign ge_high = (cif.result >= cif.high_sp);
    assign le_low = (cif.result <= cif.low_sp);
    assign cif.active = thr_r.active;
    assign cif.hi_hit = thr_r.hi_hit;
    assign cif.lo_hit = thr_r.lo_hit;

    always_comb begin
        thr_nxt = thr_r;
        thr_nxt.hi_hit = 1'b0;
        thr_nxt.lo_hit = 1'b0;
        if (cif.update) begin
            thr_nxt.hi_hit = ge_high;
            thr_nxt.lo_hit = le_low;
            if (ge_high) begin
                thr_nxt.active = 1'b1;
            end else if (le_low) begin
                thr_nxt.active = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            thr_r <= '0;
        end else if (cif.en) begin
            thr_r <= thr_nxt;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_trip_high;
        (cif.en && cif.update && ge_high) |=> thr_r.active;
    endproperty
    a_trip_high: assert property (p_trip_high) else $error("alarm not raised");
    property p_release_low;
        (cif.en && cif.update && le_low && !ge_high) |=> !thr_r.active;
    endproperty
    a_release_low: assert property (p_release_low) else $error("alarm not released");
    property p_hold_between;
        !cif.update |=> $stable(thr_r.active);
    endproperty
    a_hold_between: assert property (p_hold_between) else $error("alarm moved");

endmodule
`default_nettype wire

// ===== rtl/temp_conversion_thermostat.sv
// Notes on behaviour
// - No conversion runs after reset until a start-convert command arrives.
// - Conversions after reset use 12-bit resolution unless configured first.
// - Reading temperature returns last result and leaves the running conversion alone.
// - Single mode: one conversion per start command, store, then standby.
// - Continuous mode keeps converting, overwriting the result; it is the default.
// - Resolution 9 to 12 bits, steps 0.5 down to 0.0625 degrees.
// - Conversion time doubles per bit, 93.75 ms at 9 bits, 750 ms at 12.
// - Configuration is volatile, defaults at reset; host should configure before starting.
// - Configuration holds mode, resolution, polarity and four status bits.
// - High setpoint resets to 80 degrees, low setpoint to 75 degrees.
// - Alarm is re-evaluated against both setpoints whenever a conversion completes.
// - Alarm turns active when result is at or above the high setpoint.
// - Alarm stays active until a result is at or below the low setpoint.
// - Alarm active level is programmable, active high after reset.
// - Read-temperature command returns the temperature result.
// - Results are 16-bit two's complement, integer in upper byte.
// - Unused low result bits read zero below 12-bit resolution.
// - Commands are 8-bit codes; bytes travel most significant bit first.
// - Device answers only its own 3-bit address; master addresses uniquely.
// - Resolution select 00,01,10,11 give 9,10,11,12 bits.
// - Done bit is read-only: 1 after reset or a single-mode completion, 0 while converting.
// - Configuration reached by code ACh; read/write bit sets the direction.
// - Setpoints reached by codes A1h and A2h, same format as result.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module temp_conversion_thermostat #(
    parameter int unsigned CONV9_CYCLES = tc_pkg::CONV9_MAX_CYC
) (
    input wire logic ref_clk,             // Core clock, 40 MHz
    input wire logic reset,               // Synchronous reset, active high
    input wire logic clk_en,              // Freezes all state when low
    input wire logic hsel,                // AHB select
    input wire logic [31:0] haddr,        // AHB address
    input wire logic [1:0] htrans,        // AHB transfer type
    input wire logic hwrite,              // AHB write
    input wire logic [2:0] hsize,         // AHB size
    input wire logic [31:0] hwdata,       // AHB write data
    input wire logic hready,              // AHB bus ready
    output logic hreadyout,               // AHB slave ready
    output logic [31:0] hrdata,           // AHB read data
    output logic hresp,                   // AHB response, always OKAY
    input wire logic bus_addr_sel_0,      // Device address pin 0
    input wire logic bus_addr_sel_1,      // Device address pin 1
    input wire logic bus_addr_sel_2,      // Device address pin 2
    input wire logic [15:0] sensor_code,  // Front-end code, left-justified
    output logic thermal_alarm_out        // Thermostat output pin
);
    import tc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic [15:0] sens_s1;
        logic [15:0] sens_s2;
        logic [15:0] sens_s3;
        logic [15:0] sens_ok;
        logic [7:0] addr;
        logic wr_pend;
        logic rd_wait;
        logic [31:0] rdata;
        logic oneshot;
        logic alarm_polarity;
        res_t res;
        logic started;
        logic running;
        logic hi_flag;
        logic lo_flag;
        logic [15:0] temp;
        logic [15:0] high_sp;
        logic [15:0] low_sp;
        logic [15:0] data;
        logic ack;
        logic nack;
        logic start;
        logic update;
        logic alarm_pin;
    } top_t;

    top_t st_r;
    top_t st_nxt;
    conv_if cif();

    logic bus_take;
    logic cmd_write;
    logic data_write;
    logic addr_match;
    logic [7:0] cmd_code;
    logic cmd_rd;
    logic [15:0] cur_mask;
    logic [7:0] cfg_byte;
    logic [31:0] read_word;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign bus_take = hsel && hready && htrans[1];
    assign cmd_write = st_r.wr_pend && (st_r.addr == OFS_CMD);
    assign data_write = st_r.wr_pend && (st_r.addr == OFS_DATA);
    assign cmd_code = hwdata[CMD_CODE_LSB +: 8];
    assign cmd_rd = hwdata[CMD_RW_BIT];
    assign addr_match = (hwdata[CMD_ADDR_LSB +: 3] == st_r.pin_s2);
    assign cur_mask = res_mask(st_r.res);
    // Done reads 0 for the whole continuous run, not just while counting
    assign cfg_byte = {!st_r.running, st_r.hi_flag, st_r.lo_flag, st_r.started,
                       st_r.res, st_r.alarm_polarity, st_r.oneshot};

    // Reads take one wait state so a write just before is always seen
    assign hreadyout = !st_r.rd_wait;
    assign hrdata = st_r.rdata;
    assign hresp = 1'b0;
    assign thermal_alarm_out = st_r.alarm_pin;

    assign cif.en = clk_en;
    assign cif.start = st_r.start;
    assign cif.res = st_r.res;
    assign cif.update = st_r.update;
    assign cif.result = st_r.temp;
    assign cif.high_sp = st_r.high_sp & cur_mask;
    assign cif.low_sp = st_r.low_sp & cur_mask;

    always_comb begin
        read_word = '0;
        case (st_r.addr)
            OFS_DATA: begin
                read_word[15:0] = st_r.data;
            end
            OFS_STATUS: begin
                read_word[ST_ACK_BIT] = st_r.ack;
                read_word[ST_NACK_BIT] = st_r.nack;
                read_word[ST_BUSY_BIT] = cif.busy;
                read_word[ST_PINS_LSB +: 3] = st_r.pin_s2;
            end
            default: begin
                read_word = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_s1 = {bus_addr_sel_2, bus_addr_sel_1, bus_addr_sel_0};
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.sens_s1 = sensor_code;
        st_nxt.sens_s2 = st_r.sens_s1;
        st_nxt.sens_s3 = st_r.sens_s2;
        // Sensor word is a bus: take it only once two samples agree
        if (st_r.sens_s2 == st_r.sens_s3) begin
            st_nxt.sens_ok = st_r.sens_s2;
        end
        st_nxt.start = 1'b0;
        st_nxt.update = 1'b0;
        st_nxt.wr_pend = 1'b0;

        if (st_r.rd_wait) begin
            st_nxt.rdata = read_word;
            st_nxt.rd_wait = 1'b0;
        end
        if (bus_take) begin
            st_nxt.addr = haddr[7:0];
            st_nxt.wr_pend = hwrite && (hsize == HSIZE_WORD);
            st_nxt.rd_wait = !hwrite;
        end

        // Completion first, so a start command in the same cycle still counts
        if (cif.done) begin
            st_nxt.temp = st_r.sens_ok & cur_mask;
            st_nxt.update = 1'b1;
            if (st_r.oneshot) begin
                st_nxt.running = 1'b0;
            end else begin
                st_nxt.start = 1'b1;
            end
        end

        if (cmd_write) begin
            if (!addr_match) begin
                st_nxt.ack = 1'b0;
                st_nxt.nack = 1'b1;
            end else begin
                st_nxt.ack = 1'b1;
                st_nxt.nack = 1'b0;
                case (cmd_code)
                    START_CONVERT_CMD: begin
                        if (!st_nxt.running) begin
                            st_nxt.start = 1'b1;
                            st_nxt.running = 1'b1;
                            st_nxt.started = 1'b1;
                        end
                    end
                    READ_TEMP_CMD: begin
                        st_nxt.data = st_r.temp;
                    end
                    CONFIG_ACCESS_CMD: begin
                        if (cmd_rd) begin
                            st_nxt.data = {8'h00, cfg_byte};
                        end else begin
                            st_nxt.oneshot = st_r.data[CFG_ONESHOT_BIT];
                            st_nxt.alarm_polarity = st_r.data[CFG_POL_BIT];
                            st_nxt.res = res_t'(st_r.data[CFG_RES_HI_BIT:CFG_RES_LO_BIT]);
                            if (!st_r.data[CFG_HIFLAG_BIT]) begin
                                st_nxt.hi_flag = 1'b0;
                            end
                            if (!st_r.data[CFG_LOFLAG_BIT]) begin
                                st_nxt.lo_flag = 1'b0;
                            end
                        end
                    end
                    HIGH_SETPOINT_ACCESS_CMD: begin
                        if (cmd_rd) begin
                            st_nxt.data = st_r.high_sp;
                        end else begin
                            st_nxt.high_sp = st_r.data & RESULT_MASK_12;
                        end
                    end
                    LOW_SETPOINT_ACCESS_CMD: begin
                        if (cmd_rd) begin
                            st_nxt.data = st_r.low_sp;
                        end else begin
                            st_nxt.low_sp = st_r.data & RESULT_MASK_12;
                        end
                    end
                    default: begin
                        st_nxt.ack = 1'b0;
                        st_nxt.nack = 1'b1;
                    end
                endcase
            end
        end
        if (data_write) begin
            st_nxt.data = hwdata[15:0];
        end

        // Flags set after the clear, so an event never gets lost
        if (cif.hi_hit) begin
            st_nxt.hi_flag = 1'b1;
        end
        if (cif.lo_hit) begin
            st_nxt.lo_flag = 1'b1;
        end
        st_nxt.alarm_pin = st_r.alarm_polarity ? cif.active : !cif.active;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= '0;
            st_r.alarm_polarity <= POL_RST;
            st_r.oneshot <= ONESHOT_RST;
            st_r.res <= RES_RST;
            st_r.high_sp <= HIGH_RST;
            st_r.low_sp <= LOW_RST;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    conv_timer #(
        .CONV9_CYCLES(CONV9_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .reset(reset),
        .cif(cif.timer)
    );

    thermostat u_thermo (
        .ref_clk(ref_clk),
        .reset(reset),
        .cif(cif.thermo)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic cfg_seen_h;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_seen_h <= 1'b0;
        end else if (clk_en && cmd_write && addr_match && cmd_code == CONFIG_ACCESS_CMD) begin
            cfg_seen_h <= 1'b1;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_store;
        cif.done && !st_r.oneshot && clk_en;
    endsequence
    sequence s_restart;
        cif.start ##1 cif.busy;
    endsequence

    property p_idle_until_start;
        !st_r.started |-> !cif.busy;
    endproperty
    a_idle_until_start: assert property (p_idle_until_start) else $error("early conversion");
    property p_default_res;
        (cif.start && !cfg_seen_h) |-> (cif.res == RES_12);
    endproperty
    a_default_res: assert property (p_default_res) else $error("not 12-bit default");
    property p_single_stops;
        (cif.done && st_r.oneshot && clk_en && !cmd_write) |=> !st_r.running ##0 !cif.busy;
    endproperty
    a_single_stops: assert property (p_single_stops) else $error("single mode kept running");
    property p_continuous;
        s_store |=> (st_r.temp == ($past(st_r.sens_ok) & $past(cur_mask))) ##0 s_restart;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous run broke");
    property p_low_bits;
        (cif.done && clk_en) |=> ((st_r.temp & ~$past(cur_mask)) == 16'h0000);
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("unused bits not zero");
    property p_done_bit;
        cif.busy |-> !cfg_byte[CFG_DONE_BIT];
    endproperty
    a_done_bit: assert property (p_done_bit) else $error("done bit set while busy");
    property p_foreign_addr;
        (cmd_write && !addr_match && clk_en) |=>
            st_r.nack && $stable(st_r.high_sp) && $stable(st_r.low_sp) && $stable(st_r.res);
    endproperty
    a_foreign_addr: assert property (p_foreign_addr) else $error("foreign command acted");
    property p_read_temp;
        // A restart pulse moves busy on its own, so that cycle is left out
        (cmd_write && addr_match && cmd_code == READ_TEMP_CMD && clk_en && !cif.done
            && !cif.start) |=>
            (st_r.data == $past(st_r.temp)) && $stable(cif.busy);
    endproperty
    a_read_temp: assert property (p_read_temp) else $error("read disturbed result");
    property p_alarm_level;
        clk_en |=> (thermal_alarm_out == ($past(st_r.alarm_polarity) ~^ $past(cif.active)));
    endproperty
    a_alarm_level: assert property (p_alarm_level) else $error("alarm level wrong");
    property p_reset_values;
        $fell(reset) |-> (st_r.high_sp == HIGH_RST) && (st_r.low_sp == LOW_RST) && st_r.alarm_polarity;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values");

endmodule
`default_nettype wire

// ===== tb/ahb_host.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_host (
    input wire logic ref_clk,       // Clock
    output logic hsel,              // Select
    output logic [31:0] haddr,      // Address
    output logic [1:0] htrans,      // Transfer type
    output logic hwrite,            // Write
    output logic [2:0] hsize,       // Size
    output logic [31:0] hwdata,     // Write data
    input wire logic hready,        // Slave ready
    input wire logic [31:0] hrdata, // Read data
    output logic hung               // A wait ran out
);
    import tc_pkg::*;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        hung = 1'b0;
    end
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Bounded, so a stuck slave ends the run instead of hanging it
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hready !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        if (hready !== 1'b1) hung <= 1'b1;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask
    task automatic cmd(input logic [7:0] code, input logic [2:0] dev, input logic rw);
        logic [31:0] q;
        xfer(1'b1, OFS_CMD, {20'h0, rw, dev, code}, q);
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
end
module tb;
    import tc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] sensor_code = 16'h0000;
    logic [2:0] pins = 3'h5;
    wire logic hsel, hwrite, hreadyout, hresp, alarm, hung;
    wire logic [1:0] htrans;
    wire logic [2:0] hsize;
    wire logic [31:0] haddr, hwdata, hrdata;
    int err_total = 0;
    int n_checks = 0;
    logic [31:0] q;
    always #12.5 ref_clk = ~ref_clk;
    ahb_host ahb_host_i (.ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hung(hung));
    temp_conversion_thermostat #(.CONV9_CYCLES(8)) temp_conversion_thermostat_i (
        .ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus_addr_sel_0(pins[0]),
        .bus_addr_sel_1(pins[1]), .bus_addr_sel_2(pins[2]), .sensor_code(sensor_code),
        .thermal_alarm_out(alarm));
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic getreg(input logic [7:0] code);
        ahb_host_i.cmd(code, pins, 1'b1);
        ahb_host_i.xfer(1'b0, OFS_DATA, 32'h0, q);
    endtask
    task automatic putreg(input logic [7:0] code, input logic [15:0] d);
        ahb_host_i.xfer(1'b1, OFS_DATA, {16'h0, d}, q);
        ahb_host_i.cmd(code, pins, 1'b0);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Two 12-bit periods of 64 cycles, plus the alarm's few cycles of lag
    task automatic newtemp(input logic [15:0] v);
        @(posedge ref_clk);
        sensor_code <= v;
        settle(150);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        newtemp(16'h1234);
        ahb_host_i.xfer(1'b0, OFS_STATUS, 32'h0, q);
        `CHK("busy", 1'b0, q[ST_BUSY_BIT])
        getreg(READ_TEMP_CMD);
        `CHK("temp", 16'h0000, q[15:0])
        getreg(CONFIG_ACCESS_CMD);
        `CHK("cfg", 8'h8e, q[7:0])
        getreg(HIGH_SETPOINT_ACCESS_CMD);
        `CHK("high", 16'h5000, q[15:0])
        ahb_host_i.cmd(8'h00, pins, 1'b0);
        ahb_host_i.xfer(1'b0, OFS_STATUS, 32'h0, q);
        `CHK("bad_code", 2'b10, q[1:0])
        `CHK("hresp", 1'b0, hresp)
        getreg(LOW_SETPOINT_ACCESS_CMD);
        `CHK("low", 16'h4b00, q[15:0])
        `CHK("alarm", 1'b0, alarm)
        ahb_host_i.cmd(READ_TEMP_CMD, ~pins, 1'b1);
        ahb_host_i.xfer(1'b0, OFS_STATUS, 32'h0, q);
        `CHK("nack", 2'b10, q[1:0])
    endtask
    task automatic t_single();
        int n;
        for (int r = 0; r < 4; r++) begin
            newtemp(16'he6ff);
            putreg(CONFIG_ACCESS_CMD, {12'h0, 2'(r), 2'b11});
            ahb_host_i.cmd(START_CONVERT_CMD, pins, 1'b0);
            n = 0;
            do begin
                ahb_host_i.xfer(1'b0, OFS_STATUS, 32'h0, q);
                n++;
            end while (q[ST_BUSY_BIT] !== 1'b0 && n < 40);
            `CHK("idle", 1'b0, q[ST_BUSY_BIT])
            if (q[ST_BUSY_BIT] !== 1'b0) finish_test();
            getreg(READ_TEMP_CMD);
            `CHK("temp", 16'he6ff & (16'hfff0 << (3 - r)), q[15:0])
            newtemp(16'h1910);
            getreg(READ_TEMP_CMD);
            `CHK("kept", 16'he6ff & (16'hfff0 << (3 - r)), q[15:0])
        end
    endtask
    task automatic t_alarm();
        @(posedge ref_clk);
        sensor_code <= 16'h5000;
        putreg(CONFIG_ACCESS_CMD, 16'h000e);
        ahb_host_i.cmd(START_CONVERT_CMD, pins, 1'b0);
        settle(150);
        `CHK("alarm_on", 1'b1, alarm)
        getreg(CONFIG_ACCESS_CMD);
        `CHK("cfg_run", 3'b011, {q[7], q[6], q[4]})
        newtemp(16'h4c00);
        `CHK("alarm_hold", 1'b1, alarm)
        getreg(READ_TEMP_CMD);
        `CHK("temp_new", 16'h4c00, q[15:0])
        newtemp(16'h4b00);
        `CHK("alarm_off", 1'b0, alarm)
        putreg(CONFIG_ACCESS_CMD, 16'h000c);
        settle(150);
        `CHK("alarm_pol", 1'b1, alarm)
        putreg(HIGH_SETPOINT_ACCESS_CMD, 16'h4b07);
        getreg(HIGH_SETPOINT_ACCESS_CMD);
        `CHK("high", 16'h4b00, q[15:0])
        settle(150);
        `CHK("alarm_low", 1'b0, alarm)
        // Mid-run reset with a changed setup must bring back the defaults
        @(posedge ref_clk);
        reset <= 1'b1;
        settle(10);
        reset <= 1'b0;
        getreg(CONFIG_ACCESS_CMD);
        `CHK("cfg_again", 8'h8e, q[7:0])
        `CHK("alarm_again", 1'b0, alarm)
        getreg(HIGH_SETPOINT_ACCESS_CMD);
        `CHK("high_again", 16'h5000, q[15:0])
    endtask
    initial begin
        settle(10);
        reset <= 1'b0;
        t_reset();
        t_single();
        t_alarm();
        finish_test();
    end
    always @(posedge hung) begin
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
